// ===== verilog/bpb_pkg.sv
package bpb_pkg;

  // ----------------------------------------------------------------
  // Bus shape
  // ----------------------------------------------------------------
  localparam int BPB_IO_AW = 16;  // 64 Kbyte I/O space
  localparam int BPB_DW    = 16;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int BPB_CLK_HZ      = 25000000;
  localparam int BPB_BUS_MAX_HZ  = 12000000;
  // Bus clock enable divider; rounds up so the bus never exceeds max rate
  localparam int BPB_BUS_DIV     = (BPB_CLK_HZ + BPB_BUS_MAX_HZ - 1) / BPB_BUS_MAX_HZ;
  localparam int BPB_STROBE_CYC  = 2;   // bus clocks a strobe stays low

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] BPB_DEV_BASE_RST = 16'h0300;
  localparam logic [15:0] BPB_DEV_MASK_RST = 16'hfff0;

  // Master state, Gray along the cycle path
  typedef enum logic [2:0] {
    BPB_M_IDLE  = 3'b000,
    BPB_M_ADDR  = 3'b001,
    BPB_M_STRB  = 3'b011,
    BPB_M_DONE  = 3'b010,
    BPB_M_HELD  = 3'b110
  } bpb_mst_state_t;

endpackage : bpb_pkg

// ===== verilog/bpb_bus_if.sv
`timescale 1ns/1ns
// Backplane wires; the data enable pairs resolve into the wire value, strobe and upper enables pass through as is
interface bpb_bus_if;
  import bpb_pkg::*;
  // Master to slave
  logic                 clk_en;          // bus clock as enable pulse
  logic                 addr_latch_strobe;
  logic                 direct_io_decode_enable;
  logic                 upper_byte_lane_enable;
  logic                 upper_byte_lane_enable_oe;
  logic                 io_read_strobe_n;
  logic                 io_write_strobe_n;
  logic                 strobe_oe;
  logic                 dma_channel_ack_n;
  logic                 bus_ownership_grant;
  logic [BPB_IO_AW-1:0] addr;
  logic [BPB_DW-1:0]    m_data_o;
  logic [BPB_DW-1:0]    m_data_oe_lanes; // per-bit enable
  // Slave to master
  logic                 bus_request_n;
  logic                 io_wide_ack_pull; // open collector pull-low
  logic [BPB_DW-1:0]    s_data_o;
  logic [BPB_DW-1:0]    s_data_oe_lanes;
  // Resolved shared wires
  logic                 io_wide_transfer_ack_n;
  logic [BPB_DW-1:0]    data;

  assign io_wide_transfer_ack_n = ~io_wide_ack_pull;  // pull-up otherwise
  assign data = (m_data_o & m_data_oe_lanes) | (s_data_o & s_data_oe_lanes);

  modport master (
    output clk_en, addr_latch_strobe, direct_io_decode_enable, upper_byte_lane_enable,
           upper_byte_lane_enable_oe, io_read_strobe_n, io_write_strobe_n, strobe_oe,
           dma_channel_ack_n, bus_ownership_grant, addr, m_data_o, m_data_oe_lanes,
    input  bus_request_n, io_wide_transfer_ack_n, data
  );
  modport slave (
    input  clk_en, addr_latch_strobe, direct_io_decode_enable, upper_byte_lane_enable,
           io_read_strobe_n, io_write_strobe_n, dma_channel_ack_n, bus_ownership_grant,
           addr, data,
    output bus_request_n, io_wide_ack_pull, s_data_o, s_data_oe_lanes
  );
endinterface : bpb_bus_if

// ===== verilog/bpb_slave.sv
`timescale 1ns/1ns
// Slave board: I/O register window plus a secondary-master request
module bpb_slave (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  bpb_bus_if.slave                        bus,
  input  wire logic [bpb_pkg::BPB_IO_AW-1:0] i_base,
  input  wire logic [bpb_pkg::BPB_IO_AW-1:0] i_mask,
  input  wire logic                       i_wide_capable,
  input  wire logic                       i_dma_req,
  input  wire logic [bpb_pkg::BPB_DW-1:0] i_rd_data,
  output logic      [bpb_pkg::BPB_DW-1:0] o_wr_data,
  output logic                            o_wr_valid,
  output logic                            o_wr_upper,
  output logic                            o_dma_owner
);
  import bpb_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]           rd_s;
    logic [1:0]           wr_s;
    logic [1:0]           dma_channel_ack_n_s;
    logic [1:0]           grant_s;
    logic                 wr_seen;
    logic                 req_n;
    logic [BPB_DW-1:0]    dout;
    logic [BPB_DW-1:0]    doe;
    logic [BPB_DW-1:0]    wdata;
    logic                 wvalid;
    logic                 wupper;
    logic                 owner;
  } bpb_slv_t;

  bpb_slv_t s_reg, s_next;
  logic     sel;
  logic     hit;

  // Address decode; the latch strobe is deliberately never read
  // Only I/O space is decoded; a memory window added later must skip the enable
  always_comb begin
    sel = bus.direct_io_decode_enable
          && ((bus.addr & i_mask) == (i_base & i_mask));
    hit = sel || !s_reg.dma_channel_ack_n_s[1];
  end

  always_comb begin
    s_next         = s_reg;
    s_next.rd_s    = {s_reg.rd_s[0], bus.io_read_strobe_n};
    s_next.wr_s    = {s_reg.wr_s[0], bus.io_write_strobe_n};
    s_next.dma_channel_ack_n_s  = {s_reg.dma_channel_ack_n_s[0], bus.dma_channel_ack_n};
    s_next.grant_s = {s_reg.grant_s[0], bus.bus_ownership_grant};
    s_next.wvalid  = 1'b0;
    // Read: drive low lanes, upper lanes only when enabled
    if (!s_reg.rd_s[1] && hit) begin
      s_next.dout = i_rd_data;
      s_next.doe  = {{8{bus.upper_byte_lane_enable}}, 8'hff};
    end else begin
      s_next.doe  = '0;
    end
    // Write: capture once per strobe
    if (!s_reg.wr_s[1] && hit && !s_reg.wr_seen) begin
      s_next.wdata   = bus.data;
      s_next.wupper  = bus.upper_byte_lane_enable;
      s_next.wvalid  = 1'b1;
      s_next.wr_seen = 1'b1;
    end
    if (s_reg.wr_s[1])
      s_next.wr_seen = 1'b0;
    // Request held while DMA wants the bus; totem-pole, always driven
    s_next.req_n = !i_dma_req;
    s_next.owner = i_dma_req && s_reg.grant_s[1];
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_reg <= '{rd_s: 2'b11, wr_s: 2'b11, dma_channel_ack_n_s: 2'b11, req_n: 1'b1, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.bus_request_n    = s_reg.req_n;
  // Wide ack follows the address without a register, so it never outlives an even address
  assign bus.io_wide_ack_pull = sel && i_wide_capable && !bus.addr[0];
  assign bus.s_data_o         = s_reg.dout;
  assign bus.s_data_oe_lanes  = s_reg.doe;
  assign o_wr_data            = s_reg.wdata;
  assign o_wr_valid           = s_reg.wvalid;
  assign o_wr_upper           = s_reg.wupper;
  assign o_dma_owner          = s_reg.owner;
endmodule : bpb_slave

// ===== verilog/bpb_master.sv
`timescale 1ns/1ns
// Primary master: runs I/O cycles, splits words, hands the bus over
module bpb_master (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst_n,
  bpb_bus_if.master                          bus,
  input  wire logic                          i_req,
  input  wire logic                          i_write,
  input  wire logic                          i_wide,
  input  wire logic                          i_special,
  input  wire logic [bpb_pkg::BPB_IO_AW-1:0] i_addr,
  input  wire logic [bpb_pkg::BPB_DW-1:0]    i_wdata,
  output logic                               o_busy,
  output logic                               o_done,
  output logic      [bpb_pkg::BPB_DW-1:0]    o_rdata,
  output logic                               o_granted
);
  import bpb_pkg::*;

  typedef struct packed {
    bpb_mst_state_t       st;
    logic [3:0]           div;
    logic                 ce;
    logic [2:0]           cnt;
    logic                 split;   // second byte of a split word pending
    logic                 write;
    logic                 wide;
    logic                 special;
    logic [BPB_IO_AW-1:0] addr;
    logic [BPB_DW-1:0]    wdata;
    logic [BPB_DW-1:0]    rdata;
    logic                 ale;
    logic                 ube;
    logic                 rd_n;
    logic                 wr_n;
    logic                 soe;
    logic [BPB_DW-1:0]    doe;
    logic                 grant;
    logic [1:0]           req_s;
    logic [1:0]           ack_s;
    logic                 done;
  } bpb_mst_t;

  bpb_mst_t m_reg, m_next;

  always_comb begin
    m_next      = m_reg;
    m_next.done = 1'b0;
    m_next.ale  = 1'b0;
    m_next.req_s = {m_reg.req_s[0], bus.bus_request_n};
    m_next.ack_s = {m_reg.ack_s[0], bus.io_wide_transfer_ack_n};
    // Bus clock enable, never faster than the bus maximum
    m_next.ce  = (m_reg.div == 4'(BPB_BUS_DIV - 1));
    m_next.div = m_next.ce ? 4'h0 : m_reg.div + 4'h1;
    if (m_reg.ce) begin
      case (m_reg.st)
        BPB_M_IDLE: begin
          if (!m_reg.req_s[1]) begin
            m_next.grant = 1'b1;
            m_next.soe   = 1'b0;
            m_next.doe   = '0;
            m_next.st    = BPB_M_HELD;
          end else if (i_req) begin
            m_next.write   = i_write;
            m_next.wide    = i_wide && !i_addr[0];
            m_next.special = i_special;
            m_next.addr    = i_addr;
            m_next.wdata   = i_wdata;
            m_next.ale     = 1'b1;
            m_next.st      = BPB_M_ADDR;
          end
        end
        BPB_M_ADDR: begin
          // Upper lane only for an even word the slave already acknowledges; an even word it
          // cannot take goes out as two byte cycles (an odd word as its low byte only), so the slave never sees a word strobe
          m_next.ube  = m_reg.wide && !m_reg.split && !m_reg.addr[0] && !m_reg.ack_s[1];
          m_next.rd_n = m_reg.write;
          m_next.wr_n = !m_reg.write;
          m_next.doe  = m_reg.write ? (m_next.ube ? 16'hffff : 16'h00ff) : 16'h0000;
          m_next.cnt  = 3'h0;
          m_next.st   = BPB_M_STRB;
        end
        BPB_M_STRB: begin
          m_next.cnt = m_reg.cnt + 3'h1;
          if (m_reg.cnt == 3'(BPB_STROBE_CYC - 1)) begin
            m_next.rd_n = 1'b1;
            m_next.wr_n = 1'b1;
            m_next.doe  = '0;
            if (!m_reg.split)
              m_next.rdata[7:0] = bus.data[7:0];
            else
              m_next.rdata[15:8] = bus.data[7:0];
            if (m_reg.ube)
              m_next.rdata[15:8] = bus.data[15:8];
            // Unacknowledged word went out as its low byte; high byte is a cycle of its own
            if (m_reg.wide && !m_reg.split && !m_reg.ube) begin
              m_next.split = 1'b1;
              m_next.ube   = 1'b0;
              m_next.ale   = 1'b1;
              m_next.st    = BPB_M_ADDR;
            end else begin
              m_next.st = BPB_M_DONE;
            end
          end
        end
        BPB_M_DONE: begin
          m_next.ube   = 1'b0;
          m_next.split = 1'b0;
          m_next.done  = 1'b1;
          m_next.st    = BPB_M_IDLE;
        end
        BPB_M_HELD: begin
          // Resume only once the request is released
          if (m_reg.req_s[1]) begin
            m_next.grant = 1'b0;
            m_next.soe   = 1'b1;
            m_next.st    = BPB_M_IDLE;
          end
        end
        default: m_next.st = BPB_M_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      m_reg <= '{st: BPB_M_IDLE, rd_n: 1'b1, wr_n: 1'b1, soe: 1'b1, req_s: 2'b11,
                 ack_s: 2'b11, default: '0};
    end else begin
      m_reg <= m_next;
    end
  end

  // Second byte addresses the odd location
  assign bus.addr = m_reg.split ? (m_reg.addr | 16'h0001) : m_reg.addr;
  assign bus.m_data_o = m_reg.split ? {8'h00, m_reg.wdata[15:8]} : m_reg.wdata;
  assign bus.clk_en                    = m_reg.ce;
  assign bus.addr_latch_strobe         = m_reg.ale;
  assign bus.direct_io_decode_enable   = !m_reg.special;
  assign bus.upper_byte_lane_enable    = m_reg.ube;
  assign bus.upper_byte_lane_enable_oe = m_reg.soe;
  assign bus.io_read_strobe_n          = m_reg.rd_n;
  assign bus.io_write_strobe_n         = m_reg.wr_n;
  assign bus.strobe_oe                 = m_reg.soe;
  assign bus.dma_channel_ack_n         = !(m_reg.special && (!m_reg.rd_n || !m_reg.wr_n));
  assign bus.m_data_oe_lanes           = m_reg.doe;
  assign bus.bus_ownership_grant       = m_reg.grant;
  assign o_busy    = (m_reg.st != BPB_M_IDLE);
  assign o_done    = m_reg.done;
  assign o_rdata   = m_reg.rdata;
  assign o_granted = m_reg.grant;
endmodule : bpb_master

// ===== tb/bpb_chk.sv
`timescale 1ns/1ns
// ----
// Backplane checker
// ----
module bpb_chk (
  input logic        i_clk,
  input logic        i_rst_n,
  input logic        addr_latch_strobe,
  input logic        direct_io_decode_enable,
  input logic        upper_byte_lane_enable,
  input logic        upper_byte_lane_enable_oe,
  input logic        io_read_strobe_n,
  input logic        io_write_strobe_n,
  input logic        strobe_oe,
  input logic        dma_channel_ack_n,
  input logic        bus_ownership_grant,
  input logic [15:0] addr,
  input logic        bus_request_n,
  input logic        io_wide_ack_pull,
  input logic        io_wide_transfer_ack_n,
  input logic [15:0] s_data_oe_lanes
);
  logic [3:0] ale_age_reg;
  logic       ube_on;
  logic       strb_low;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Strobe and upper enable count only while the master really drives them
  assign ube_on   = upper_byte_lane_enable & upper_byte_lane_enable_oe;
  assign strb_low = strobe_oe & ~(io_read_strobe_n & io_write_strobe_n);

  // Age of the last address latch pulse; saturates so it cannot wrap to a false match
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ale_age_reg <= 4'hf;
    end else if (addr_latch_strobe) begin
      ale_age_reg <= 4'h0;
    end else if (ale_age_reg != 4'hf) begin
      ale_age_reg <= ale_age_reg + 4'h1;
    end
  end

  AST_ALE_LEADS: assert property ($rose(strb_low) |-> ale_age_reg <= 4'h6)
    else $error("strobe without a recent address latch pulse");
  AST_UBE_EVEN: assert property (ube_on && strb_low |-> !addr[0])
    else $error("upper enable at odd address");
  AST_UBE_ACKED: assert property (ube_on && strb_low |-> !io_wide_transfer_ack_n)
    else $error("word cycle without wide acknowledge");
  AST_ACK_EVEN: assert property (io_wide_ack_pull |-> !addr[0])
    else $error("wide acknowledge at odd address");
  AST_UPPER_LANES: assert property (|s_data_oe_lanes[15:8] |-> ube_on)
    else $error("upper lanes driven without upper enable");
  AST_SELECT_GATED: assert property (|s_data_oe_lanes |-> direct_io_decode_enable || !dma_channel_ack_n)
    else $error("slave drives data while not selected");
  AST_GRANT_ON_REQ: assert property ($rose(bus_ownership_grant) |-> !bus_request_n)
    else $error("grant without request");
  AST_RELEASED_GRANTED: assert property (bus_ownership_grant |-> !strobe_oe && !upper_byte_lane_enable_oe)
    else $error("master drives strobes while bus is granted");
  AST_GRANT_DROPS: assert property ($rose(bus_request_n) |-> ##[0:12] !bus_ownership_grant)
    else $error("grant held after request release");
  AST_ADDR_STABLE: assert property (strb_low && $past(strb_low) |-> $stable(addr))
    else $error("address moved under an active strobe");
endmodule : bpb_chk

// ===== tb/backplane_bus_control_signals_tb.sv
`timescale 1ns/1ns
// ----
// Master and slave face each other across one bus
// ----
module backplane_bus_control_signals_tb;
  import bpb_pkg::*;
  logic        i_clk, i_rst_n, req, wr, wide, spec, wcap, dreq, busy, done, granted, wvalid, wupper, owner;
  logic [15:0] addr, wdata, rdata, srd, wdat_s;
  logic [16:0] wq[$];
  int          mismatches, n_compared;

  bpb_bus_if bus ();
  bpb_master i_bpb_master (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(bus), .i_req(req), .i_write(wr),
    .i_wide(wide), .i_special(spec), .i_addr(addr), .i_wdata(wdata), .o_busy(busy), .o_done(done),
    .o_rdata(rdata), .o_granted(granted));
  bpb_slave i_bpb_slave (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(bus), .i_base(BPB_DEV_BASE_RST),
    .i_mask(BPB_DEV_MASK_RST), .i_wide_capable(wcap), .i_dma_req(dreq), .i_rd_data(srd),
    .o_wr_data(wdat_s), .o_wr_valid(wvalid), .o_wr_upper(wupper), .o_dma_owner(owner));
  bpb_chk i_bpb_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .addr_latch_strobe(bus.addr_latch_strobe),
    .direct_io_decode_enable(bus.direct_io_decode_enable), .upper_byte_lane_enable(bus.upper_byte_lane_enable),
    .upper_byte_lane_enable_oe(bus.upper_byte_lane_enable_oe), .io_read_strobe_n(bus.io_read_strobe_n),
    .io_write_strobe_n(bus.io_write_strobe_n), .strobe_oe(bus.strobe_oe), .dma_channel_ack_n(bus.dma_channel_ack_n),
    .bus_ownership_grant(bus.bus_ownership_grant), .addr(bus.addr), .bus_request_n(bus.bus_request_n),
    .io_wide_ack_pull(bus.io_wide_ack_pull), .io_wide_transfer_ack_n(bus.io_wide_transfer_ack_n),
    .s_data_oe_lanes(bus.s_data_oe_lanes));

  // 25 MHz system clock
  always #20 i_clk = ~i_clk;

  // Collect every write the slave hands to its user side
  always @(posedge i_clk) begin
    if (wvalid === 1'b1) begin
      wq.push_back({wupper, wdat_s});
    end
  end

  // ----
  // Tasks
  // ----
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One master cycle; request held until the master shows busy
  task automatic xfer(input logic w, input logic wd, input logic sp, input logic [15:0] a, input logic [15:0] d);
    int k;
    req = 1'b1; wr = w; wide = wd; spec = sp; addr = a; wdata = d;
    k = 0;
    while (busy !== 1'b1 && k < 100) begin
      cyc(1);
      k++;
    end
    req = 1'b0;
    while (done !== 1'b1 && k < 400) begin
      cyc(1);
      k++;
    end
    chk("completion", 16'h0001, {15'h0, done});
    cyc(1);
  endtask : xfer

  // Check the oldest delivered write, only on the lanes given by the mask
  task automatic wexp(input logic [16:0] e, input logic [15:0] m);
    logic [16:0] g;
    g = (wq.size() > 0) ? wq.pop_front() : 17'h0;
    chk("write upper", {15'h0, e[16]}, {15'h0, g[16]});
    chk("write data", e[15:0] & m, g[15:0] & m);
  endtask : wexp

  task automatic waitg(input logic v);
    int k;
    k = 0;
    while (granted !== v && k < 200) begin
      cyc(1);
      k++;
    end
  endtask : waitg

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // ----
  // Tests
  // ----
  initial begin
    i_clk = 1'b0; i_rst_n = 1'b0; req = 1'b0; wr = 1'b0; wide = 1'b0; spec = 1'b0;
    wcap = 1'b1; dreq = 1'b0; addr = 16'h0000; wdata = 16'h0000; srd = 16'hbeef;
    mismatches = 0; n_compared = 0;
    cyc(10);
    i_rst_n = 1'b1;
    cyc(2);
    xfer(1'b1, 1'b1, 1'b0, 16'h0302, 16'ha55a);
    wexp({1'b1, 16'ha55a}, 16'hffff);
    wcap = 1'b0;
    xfer(1'b1, 1'b1, 1'b0, 16'h0304, 16'h1234);
    wexp({1'b0, 16'h0034}, 16'h00ff);
    wexp({1'b0, 16'h0012}, 16'h00ff);
    wcap = 1'b1;
    xfer(1'b1, 1'b1, 1'b0, 16'h0307, 16'h5678);
    wexp({1'b0, 16'h0078}, 16'h00ff);
    xfer(1'b1, 1'b1, 1'b0, 16'h0400, 16'hffff);
    chk("writes left", 16'h0000, 16'(wq.size()));
    xfer(1'b0, 1'b1, 1'b0, 16'h0306, 16'h0000);
    chk("read word", 16'hbeef, rdata);
    xfer(1'b0, 1'b0, 1'b0, 16'h0308, 16'h0000);
    chk("read byte", 16'h00ef, rdata & 16'h00ff);
    xfer(1'b1, 1'b1, 1'b1, 16'h0302, 16'h0f0f);
    wq.delete();
    dreq = 1'b1;
    waitg(1'b1);
    chk("granted", 16'h0001, {15'h0, granted});
    cyc(3);
    chk("request line", 16'h0000, {15'h0, bus.bus_request_n});
    chk("owner", 16'h0001, {15'h0, owner});
    req = 1'b1; wr = 1'b1; wide = 1'b1; spec = 1'b0; addr = 16'h030a; wdata = 16'hc3c3;
    cyc(20);
    chk("busy while granted", 16'h0001, {15'h0, busy});
    chk("writes while granted", 16'h0000, 16'(wq.size()));
    req = 1'b0;
    dreq = 1'b0;
    waitg(1'b0);
    chk("grant released", 16'h0000, {15'h0, granted});
    xfer(1'b1, 1'b1, 1'b0, 16'h030a, 16'hc3c3);
    wexp({1'b1, 16'hc3c3}, 16'hffff);
    wrap_up();
  end

  // Cut a hang short
  initial begin
    cyc(8000);
    mismatches++;
    wrap_up();
  end
endmodule : backplane_bus_control_signals_tb
